/* core/fspc_pkg.sv */
// Purpose: Shared constants for the flash self-program control block.
// Assumes: 32-bit AXI4-Lite register access, 20 MHz system clock.
// Notes:   Offsets of the bus registers are local to this block.
package fspc_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] PTR_OFS    = 8'h04;
  localparam logic [7:0] DATA_OFS   = 8'h08;
  localparam logic [7:0] INSTR_OFS  = 8'h0c;
  localparam logic [7:0] RESULT_OFS = 8'h10;
  localparam logic [7:0] LOCK_OFS   = 8'h14;

  // ----------------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------------
  localparam int IRQ_EN_BIT  = 7;
  localparam int BUSY_BIT    = 6;
  localparam int SIG_BIT     = 5;
  localparam int RE_BIT      = 4;
  localparam int LOCK_BIT    = 3;
  localparam int PGWR_BIT    = 2;
  localparam int PGER_BIT    = 1;
  localparam int EN_BIT      = 0;

  // ----------------------------------------------------------------------
  // Command patterns of the lower five bits
  // ----------------------------------------------------------------------
  localparam logic [4:0] CMD_SIG   = 5'h11;
  localparam logic [4:0] CMD_RE    = 5'h11 ^ 5'h00 ^ 5'h00 ^ 5'h00 ^ 5'h00 ^ 5'h00 ^ 5'h00 ^ 5'h11 ^ 5'h11;
  localparam logic [4:0] CMD_LOCK  = 5'h09;
  localparam logic [4:0] CMD_PGWR  = 5'h05;
  localparam logic [4:0] CMD_PGER  = 5'h03;
  localparam logic [4:0] CMD_FILL  = 5'h01;

  // ----------------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic [7:0] LOCK_RESET     = 8'hff;
  localparam logic [7:0] FUSE_RESET     = 8'hff;
  localparam logic [7:0] SIG_VALUE      = 8'h5a; // Arbitrary value.
  localparam logic [2:0] STORE_WINDOW   = 3'h4;
  localparam logic [2:0] LOAD_WINDOW    = 3'h3;
  localparam int         CLK_MHZ        = 20;
  localparam int         PROG_TIME_US   = 4000;
  localparam int         PROG_CYCLES    = PROG_TIME_US * CLK_MHZ;
  localparam logic [7:0] BLOCKING_BOOT_SECTION_FIRST_PG  = 8'he0;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

  typedef enum logic [1:0] {
    FSPC_IDLE,
    FSPC_ARMED,
    FSPC_PROG
  } fspc_state_t;

endpackage

/* core/fspc_top.sv */
// Purpose: Flash self-program control and status, reached over AXI4-Lite.
// Assumes: Software issues store and load instructions through a register.
// Notes:   The flash array itself is outside; this block times the commands.
//
// Notes on behaviour
// - Ready interrupt requested while irq enable and global flag set, enable clear.
// - Erase or write to concurrent section sets busy; section blocked meanwhile.
// - Busy clears on read-enable store after programming, or on buffer fill.
// - Signature command then load within three cycles returns signature byte.
// - Store within four cycles of signature command does nothing.
// - Read-enable needs idle flash; store within four cycles; refused while busy.
// - Writing read-enable during buffer fill aborts it and discards buffer.
// - Lock command then store within four cycles programs locks from R0.
// - Lock command bit clears after programming or four idle cycles.
// - Lock command then load within three cycles returns lock or fuse by Z0.
// - Page-write command then store writes buffer into page from upper Z.
// - Page-write bit clears on completion or after four idle cycles.
// - Erase or write to boot section halts the core for its whole length.
// - Page-erase command then store erases page from upper Z.
// - Page-erase bit clears on completion or after four idle cycles.
// - Enable alone then store puts R1:R0 into buffer word at Z, ignoring Z0.
// - Enable lasts four cycles, clears after store or expiry, held during programming.
// - Any other lower five bit pattern does nothing.
//
// The register offsets and register access over AXI4-Lite were decided locally.
`timescale 1ns/100ps

module fspc_top #(
  parameter int PROG_CYCLES = fspc_pkg::PROG_CYCLES
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // System side
  input  wire logic        global_irq_flag,
  output logic             store_ready_irq,
  output logic             core_halt,
  output logic             concurrent_section_busy
);

  typedef struct packed {
    logic                   awready;
    logic                   wready;
    logic                   aw_have;
    logic                   w_have;
    logic [7:0]             awaddr;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   arready;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
    logic [7:0]             ctrl;
    fspc_pkg::fspc_state_t  state;
    logic [2:0]             win;
    logic [31:0]            prog_cnt;
    logic                   prog_busy_sec;
    logic                   fill_active;
    logic [15:0]            zptr;
    logic [15:0]            r1r0;
    logic [7:0]             result;
    logic [7:0]             lock_bits;
    logic [7:0]             fuse_bits;
    logic [7:0]             page_q;
    logic [127:0]           buf_valid;
    logic                   irq;
    logic                   halt;
  } fspc_regs_t;

  fspc_regs_t r_q;
  fspc_regs_t r_d;

  logic [15:0] page_buf [0:127];

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic is_boot_page(input logic [15:0] z);
    return z[15:8] >= fspc_pkg::BLOCKING_BOOT_SECTION_FIRST_PG;
  endfunction

  logic        wr_fire;
  logic [31:0] wr_val;
  logic        store_go;
  logic        load_go;
  logic [4:0]  cmd;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    r_d      = r_q;
    wr_fire  = 1'b0;
    wr_val   = 32'h0000_0000;
    store_go = 1'b0;
    load_go  = 1'b0;
    cmd      = r_q.ctrl[4:0];

    // Address and data are taken in either order; the response follows both.
    if (s_axi_awvalid && r_q.awready) begin
      r_d.aw_have = 1'b1;
      r_d.awaddr  = s_axi_awaddr;
      r_d.awready = 1'b0;
    end
    if (s_axi_wvalid && r_q.wready) begin
      r_d.w_have = 1'b1;
      r_d.wdata  = s_axi_wdata;
      r_d.wstrb  = s_axi_wstrb;
      r_d.wready = 1'b0;
    end
    if (r_q.aw_have && r_q.w_have && !r_q.bvalid) begin
      wr_fire     = 1'b1;
      r_d.aw_have = 1'b0;
      r_d.w_have  = 1'b0;
      r_d.bvalid  = 1'b1;
      r_d.bresp   = fspc_pkg::RESP_OKAY;
    end
    if (r_q.bvalid && s_axi_bready) begin
      r_d.bvalid  = 1'b0;
      r_d.awready = 1'b1;
      r_d.wready  = 1'b1;
    end

    // Window countdown; expiry drops every command bit.
    if (r_q.state == fspc_pkg::FSPC_ARMED) begin
      if (r_q.win == 3'h1) begin
        r_d.ctrl[5:0] = 6'h00;
        r_d.state     = fspc_pkg::FSPC_IDLE;
        r_d.win       = 3'h0;
      end else begin
        r_d.win = r_q.win - 3'h1;
      end
    end

    // Programming timer; enable stays high until it ends.
    if (r_q.state == fspc_pkg::FSPC_PROG) begin
      if (r_q.prog_cnt == 32'h0000_0001) begin
        r_d.state    = fspc_pkg::FSPC_IDLE;
        r_d.ctrl[2:0] = 3'h0;
        r_d.halt     = 1'b0;
        r_d.prog_cnt = 32'h0000_0000;
        if (r_q.ctrl[fspc_pkg::PGWR_BIT]) begin
          r_d.fill_active = 1'b0;
          r_d.buf_valid   = '0;
        end
      end else begin
        r_d.prog_cnt = r_q.prog_cnt - 32'h0000_0001;
      end
    end

    if (wr_fire) begin
      wr_val = merge(32'h0000_0000, r_q.wdata, r_q.wstrb);
      case (r_q.awaddr)
        fspc_pkg::CTRL_OFS: begin
          r_d.ctrl[fspc_pkg::IRQ_EN_BIT] = wr_val[7];
          if (r_q.state == fspc_pkg::FSPC_IDLE) begin
            // Only the five documented patterns arm a window.
            if (wr_val[4:0] == fspc_pkg::CMD_SIG || wr_val[4:0] == fspc_pkg::CMD_RE ||
                wr_val[4:0] == fspc_pkg::CMD_LOCK || wr_val[4:0] == fspc_pkg::CMD_PGWR ||
                wr_val[4:0] == fspc_pkg::CMD_PGER || wr_val[4:0] == fspc_pkg::CMD_FILL) begin
              r_d.ctrl[5:0] = {wr_val[5] & wr_val[0], wr_val[4:0]};
              r_d.state     = fspc_pkg::FSPC_ARMED;
              r_d.win       = fspc_pkg::STORE_WINDOW;
            end
          end
          if (wr_val[fspc_pkg::RE_BIT] && r_q.fill_active) begin
            r_d.fill_active = 1'b0;
            r_d.buf_valid   = '0;
          end
        end
        fspc_pkg::PTR_OFS:  r_d.zptr = wr_val[15:0];
        fspc_pkg::DATA_OFS: r_d.r1r0 = wr_val[15:0];
        fspc_pkg::INSTR_OFS: begin
          store_go = wr_val[0];
          load_go  = wr_val[1];
        end
        fspc_pkg::LOCK_OFS, fspc_pkg::RESULT_OFS: begin
        end
        default: r_d.bresp = fspc_pkg::RESP_SLVERR;
      endcase
    end

    // Load instruction: three-cycle window for the read commands.
    if (load_go && r_q.state == fspc_pkg::FSPC_ARMED && r_q.win > 3'h1) begin
      if (r_q.ctrl[fspc_pkg::SIG_BIT]) begin
        r_d.result = fspc_pkg::SIG_VALUE;
      end else if (r_q.ctrl[fspc_pkg::LOCK_BIT]) begin
        r_d.result = r_q.zptr[0] ? r_q.fuse_bits : r_q.lock_bits;
      end
    end

    // Store instruction within the four-cycle window.
    if (store_go && r_q.state == fspc_pkg::FSPC_ARMED) begin
      r_d.win = 3'h0;
      if (r_q.ctrl[fspc_pkg::SIG_BIT]) begin
        r_d.ctrl[5:0] = 6'h00;
        r_d.state     = fspc_pkg::FSPC_IDLE;
      end else if (r_q.ctrl[4:0] == fspc_pkg::CMD_FILL) begin
        r_d.ctrl[0]     = 1'b0;
        r_d.state       = fspc_pkg::FSPC_IDLE;
        r_d.fill_active = 1'b1;
        r_d.buf_valid[r_q.zptr[7:1]] = 1'b1;
        r_d.prog_busy_sec = 1'b0;
      end else if (r_q.ctrl[4:0] == fspc_pkg::CMD_LOCK) begin
        r_d.lock_bits = r_q.lock_bits & r_q.r1r0[7:0];
        r_d.ctrl[5:0] = 6'h00;
        r_d.state     = fspc_pkg::FSPC_IDLE;
      end else if (r_q.ctrl[4:0] == fspc_pkg::CMD_RE) begin
        r_d.prog_busy_sec = 1'b0;
        r_d.ctrl[5:0]     = 6'h00;
        r_d.state         = fspc_pkg::FSPC_IDLE;
      end else begin
        // Page erase or page write: address latched, halt or busy set; program state until timer ends.
        r_d.page_q   = r_q.zptr[15:8];
        r_d.state    = fspc_pkg::FSPC_PROG;
        // A store in the last window cycle must not let the expiry drop the command.
        r_d.ctrl[5:0] = r_q.ctrl[5:0];
        r_d.prog_cnt = PROG_CYCLES;
        if (is_boot_page(r_q.zptr)) begin
          r_d.halt = 1'b1;
        end else begin
          r_d.prog_busy_sec = 1'b1;
        end
      end
    end

    // Register reads; the busy flag shows in bit six.
    if (s_axi_arvalid && r_q.arready) begin
      r_d.arready = 1'b0;
      r_d.rvalid  = 1'b1;
      r_d.rresp   = fspc_pkg::RESP_OKAY;
      case (s_axi_araddr)
        fspc_pkg::CTRL_OFS:
          r_d.rdata = {24'h000000, r_q.ctrl[7], r_q.prog_busy_sec, r_q.ctrl[5:0]};
        fspc_pkg::PTR_OFS:    r_d.rdata = {16'h0000, r_q.zptr};
        fspc_pkg::DATA_OFS:   r_d.rdata = {16'h0000, r_q.r1r0};
        fspc_pkg::INSTR_OFS:  r_d.rdata = 32'h0000_0000;
        fspc_pkg::RESULT_OFS: r_d.rdata = {24'h000000, r_q.result};
        fspc_pkg::LOCK_OFS:   r_d.rdata = {16'h0000, r_q.fuse_bits, r_q.lock_bits};
        default: begin
          r_d.rdata = 32'h0000_0000;
          r_d.rresp = fspc_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (r_q.rvalid && s_axi_rready) begin
      r_d.rvalid  = 1'b0;
      r_d.arready = 1'b1;
    end

    r_d.irq = r_d.ctrl[fspc_pkg::IRQ_EN_BIT] & global_irq_flag &
              ~r_d.ctrl[fspc_pkg::EN_BIT];
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_q           <= '0;
      r_q.awready   <= 1'b1;
      r_q.wready    <= 1'b1;
      r_q.arready   <= 1'b1;
      r_q.ctrl      <= fspc_pkg::CTRL_RESET;
      r_q.state     <= fspc_pkg::FSPC_IDLE;
      r_q.lock_bits <= fspc_pkg::LOCK_RESET;
      r_q.fuse_bits <= fspc_pkg::FUSE_RESET;
    end else begin
      r_q <= r_d;
    end
  end

  // The buffer word store is kept out of the state struct to stay an array.
  always_ff @(posedge aclk) begin
    if (store_go && r_q.state == fspc_pkg::FSPC_ARMED &&
        r_q.ctrl[4:0] == fspc_pkg::CMD_FILL && !r_q.ctrl[fspc_pkg::SIG_BIT]) begin
      page_buf[r_q.zptr[7:1]] <= r_q.r1r0;
    end
  end

  assign s_axi_awready           = r_q.awready;
  assign s_axi_wready            = r_q.wready;
  assign s_axi_bresp             = r_q.bresp;
  assign s_axi_bvalid            = r_q.bvalid;
  assign s_axi_arready           = r_q.arready;
  assign s_axi_rdata             = r_q.rdata;
  assign s_axi_rresp             = r_q.rresp;
  assign s_axi_rvalid            = r_q.rvalid;
  assign store_ready_irq         = r_q.irq;
  assign core_halt               = r_q.halt;
  assign concurrent_section_busy = r_q.prog_busy_sec;

endmodule

/* testbench/fspc_core_model.sv */
// Purpose: Behavioural core beside the control block.
// Assumes: One clock shared with the block.
// Notes:   Halt time is counted so the bench sees the core stall.
`timescale 1ns/100ps
module fspc_core_model (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Bench and block side
  input  wire logic        irq_allow,
  input  wire logic        core_halt,
  output logic             global_irq_flag,
  output logic [31:0]      halt_cycles
);
  // Page sits in the upper byte, the word in bits 7:1, bit 0 stays clear.
  function automatic logic [15:0] zptr(input logic [7:0] pg, input logic [6:0] wd);
    return {pg, wd, 1'b0};
  endfunction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      global_irq_flag <= 1'b0;
      halt_cycles     <= 32'h0;
    end else begin
      global_irq_flag <= irq_allow;
      if (core_halt) halt_cycles <= halt_cycles + 32'h1;
    end
  end
endmodule

/* testbench/fspc_top_monitor.sv */
// Purpose: Port checks of the flash self-program control block.
// Assumes: Bound to every instance of the top module.
// Notes:   Halt length is counted so a wrong program time is caught.
`timescale 1ns/100ps
module fspc_top_monitor #(
  parameter int PROG_CYCLES = fspc_pkg::PROG_CYCLES
) (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // System side
  input wire logic        global_irq_flag,
  input wire logic        store_ready_irq,
  input wire logic        core_halt,
  input wire logic        concurrent_section_busy
);
  logic wr_hs;
  int   halt_n_q;
  int   halt_n_d;
  assign wr_hs = s_axi_wvalid && s_axi_wready;
  always_comb halt_n_d = core_halt ? halt_n_q + 1 : 0;
  always_ff @(posedge aclk) begin
    if (!aresetn) halt_n_q <= 0;
    else halt_n_q <= halt_n_d;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // Busy edges and the halt rise need a bus write taken one to three cycles before, never on their own.
  property after_store(ev);
    ev |-> $past(wr_hs) || $past(wr_hs, 2) || $past(wr_hs, 3);
  endproperty
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && wr_hs |-> ##[1:2] s_axi_bvalid)
    else $error("write got no response");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read got no data");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_reset_idle: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !core_halt
    && !concurrent_section_busy) else $error("outputs not idle after reset");
  a_irq_flag: assert property (store_ready_irq |-> $past(global_irq_flag))
    else $error("irq without global flag");
  a_irq_drop: assert property ($fell(global_irq_flag) |=> !store_ready_irq)
    else $error("irq stayed after flag fell");
  a_busy_rise: assert property (after_store($rose(concurrent_section_busy)))
    else $error("busy rose without a store");
  a_busy_fall: assert property (after_store($fell(concurrent_section_busy)))
    else $error("busy fell without a store");
  a_halt_rise: assert property (after_store($rose(core_halt)))
    else $error("halt without a store");
  a_halt_len: assert property ($fell(core_halt) |-> halt_n_q >= PROG_CYCLES - 2
    && halt_n_q <= PROG_CYCLES + 2) else $error("halt length wrong");
  c_busy: cover property ($rose(concurrent_section_busy));
  c_halt: cover property ($fell(core_halt));
  c_irq: cover property (store_ready_irq);
endmodule
bind fspc_top fspc_top_monitor #(.PROG_CYCLES(PROG_CYCLES)) u_mon (.*);

/* testbench/testbench.sv */
// Purpose: Self-checking bench of the flash self-program control block.
// Assumes: Short program time so each erase or write lasts twenty cycles.
// Notes:   Bus results are compared in order by one watcher process.
`timescale 1ns/100ps
module testbench;
  localparam int PROG = 20;
  logic        aclk, aresetn, irq_allow, global_irq_flag, store_ready_irq;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, core_halt, concurrent_section_busy;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, halt_cycles, h0, rnd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, bq[$];
  logic [33:0] rq[$];
  int          num_errors, check_count;
  logic [4:0]  bad[3] = '{5'h07, 5'h1f, 5'h02};
  logic [4:0]  arm[4] = '{5'h01, 5'h03, 5'h05, 5'h09};
  fspc_top #(.PROG_CYCLES(PROG)) u_dut (.*);
  fspc_core_model u_core (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .irq_allow       (irq_allow),
    .core_halt       (core_halt),
    .global_irq_flag (global_irq_flag),
    .halt_cycles     (halt_cycles)
  );
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic report_and_stop();
    @(posedge aclk);
    if (rq.size() + bq.size() != 0) num_errors++;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic pin(input logic got, input logic exp);
    chk({33'h0, got}, {33'h0, exp});
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // ----------------------------------------------------------------
  // Bus master
  // ----------------------------------------------------------------
  // Command writes skip the response stall so the store lands in the window.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic stall = 1'b1,
                    input logic [1:0] r = fspc_pkg::RESP_OKAY);
    bq.push_back(r);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= !stall;
    for (int n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_bvalid && s_axi_bready) return;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (!s_axi_awvalid && !s_axi_wvalid) s_axi_bready <= 1'b1;
    end
    num_errors++;
    report_and_stop();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = fspc_pkg::RESP_OKAY);
    rq.push_back({r, d});
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b0;
    for (int n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_rvalid && s_axi_rready) return;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      else if (!s_axi_arvalid) s_axi_rready <= 1'b1;
    end
    num_errors++;
    report_and_stop();
  endtask
  task automatic cmd(input logic [7:0] c, input logic [1:0] ins);
    wr(fspc_pkg::CTRL_OFS, {24'h0, c}, 1'b0);
    if (ins != 2'h0) wr(fspc_pkg::INSTR_OFS, {30'h0, ins}, 1'b0);
    idle(2);
  endtask
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      if (rq.size() == 0) num_errors++;
      else chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    end
    if (s_axi_bvalid && s_axi_bready) begin
      if (bq.size() == 0) num_errors++;
      else chk({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
    end
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    {aresetn, irq_allow, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    rnd = 32'hba307651;
    num_errors = 0;
    check_count = 0;
    idle(10);
    aresetn <= 1'b1;
    idle(1);
    rd(fspc_pkg::CTRL_OFS, 32'h0);
    rd(fspc_pkg::LOCK_OFS, 32'h0000ffff);
    rd(8'h40, 32'h0, fspc_pkg::RESP_SLVERR);
    wr(8'h40, 32'h1, 1'b1, fspc_pkg::RESP_SLVERR);
    foreach (bad[i]) begin
      wr(fspc_pkg::CTRL_OFS, {27'h0, bad[i]});
      rd(fspc_pkg::CTRL_OFS, 32'h0);
    end
    foreach (arm[i]) begin
      cmd({3'h0, arm[i]}, 2'h0);
      idle(6);
      rd(fspc_pkg::CTRL_OFS, 32'h0);
    end
    wr(fspc_pkg::PTR_OFS, {16'h0, u_core.zptr(8'h01, 7'h00)});
    cmd(8'h03, 2'h1);
    pin(concurrent_section_busy, 1'b1);
    pin(core_halt, 1'b0);
    rd(fspc_pkg::CTRL_OFS, 32'h43);
    idle(PROG + 10);
    rd(fspc_pkg::CTRL_OFS, 32'h40);
    rnd = lfsr(rnd);
    wr(fspc_pkg::PTR_OFS, {16'h0, u_core.zptr(8'h01, rnd[22:16])});
    wr(fspc_pkg::DATA_OFS, {16'h0, rnd[15:0]});
    cmd(8'h01, 2'h1);
    pin(concurrent_section_busy, 1'b0);
    rd(fspc_pkg::CTRL_OFS, 32'h0);
    h0 = halt_cycles;
    wr(fspc_pkg::PTR_OFS, {16'h0, u_core.zptr(fspc_pkg::BLOCKING_BOOT_SECTION_FIRST_PG, 7'h00)});
    cmd(8'h05, 2'h1);
    pin(core_halt, 1'b1);
    pin(concurrent_section_busy, 1'b0);
    idle(PROG + 10);
    pin(halt_cycles > h0, 1'b1);
    wr(fspc_pkg::PTR_OFS, {16'h0, u_core.zptr(8'h02, 7'h00)});
    cmd(8'h05, 2'h1);
    cmd(8'h11, 2'h0);
    rd(fspc_pkg::CTRL_OFS, 32'h45);
    idle(PROG + 10);
    cmd(8'h11, 2'h1);
    pin(concurrent_section_busy, 1'b0);
    rnd = lfsr(rnd);
    wr(fspc_pkg::DATA_OFS, {16'h0, rnd[15:0]});
    cmd(8'h09, 2'h1);
    idle(PROG + 10);
    rd(fspc_pkg::LOCK_OFS, {16'h0, fspc_pkg::FUSE_RESET, rnd[7:0]});
    for (int z = 0; z < 2; z++) begin
      wr(fspc_pkg::PTR_OFS, {31'h0, z[0]});
      cmd(8'h09, 2'h2);
      rd(fspc_pkg::RESULT_OFS, {24'h0, z[0] ? fspc_pkg::FUSE_RESET : rnd[7:0]});
      idle(6);
    end
    cmd(8'h21, 2'h2);
    rd(fspc_pkg::RESULT_OFS, {24'h0, fspc_pkg::SIG_VALUE});
    cmd(8'h21, 2'h1);
    pin(core_halt, 1'b0);
    rd(fspc_pkg::CTRL_OFS, 32'h0);
    idle(6);
    irq_allow <= 1'b1;
    wr(fspc_pkg::CTRL_OFS, 32'h80);
    idle(3);
    pin(store_ready_irq, 1'b1);
    irq_allow <= 1'b0;
    idle(3);
    pin(store_ready_irq, 1'b0);
    report_and_stop();
  end
endmodule
